// ===== hdl/fwp_map.vh
// Register map, field positions and constants for the flash write-protect block
`ifndef FWP_MAP_VH
`define FWP_MAP_VH
`define FWP_ADDR_PROG 12'h000
`define FWP_ADDR_BOOT 12'h004
`define FWP_ADDR_KEY 12'h008
`define FWP_ADDR_STAT 12'h00c
`define FWP_PROG_LOCK 31
`define FWP_PROG_BND_HI 23
`define FWP_BOOT_LOCK 15
`define FWP_BOOT_G2 10
`define FWP_BOOT_G1 9
`define FWP_BOOT_G0 8
`define FWP_PROG_RST 25'h1000000
`define FWP_BOOT_RST 4'hf
`define FWP_KEY1 32'haa996655
`define FWP_KEY2 32'h556699aa
`define FWP_PROG_HI 8'h1d
`define FWP_BOOT_HI 16'h1fc0
`define FWP_BOOT_HI_LSB 16
`define FWP_LOCK_RST 1'b1
`define FWP_PAGE_LSB 11
`define FWP_BPAGE_LSB 14
`define FWP_ZERO32 32'h00000000
`endif

// ===== hdl/fwp_unlock.v
// Two-word key sequence detector that arms one protect-register write
`timescale 1ns/100ps
`include "fwp_map.vh"
module fwp_unlock (
  sys_clk,
  rst_n,
  key_wr,
  key_data,
  consume,
  armed
);
  input wire sys_clk;
  input wire rst_n;
  input wire key_wr;
  input wire [31:0] key_data;
  input wire consume;
  output reg armed;
  localparam ST_IDLE = 2'b00;
  localparam ST_HALF = 2'b01;
  localparam ST_ARMED = 2'b10;
  reg [1:0] state_q;
  reg [1:0] state_d;
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (key_wr && key_data == `FWP_KEY1) begin
          state_d = ST_HALF;
        end
      end
      ST_HALF: begin
        if (key_wr) begin
          state_d = (key_data == `FWP_KEY2) ? ST_ARMED : ST_IDLE;
        end
      end
      ST_ARMED: begin
        // Any protect write or new key write uses up the unlock
        if (consume || key_wr) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      armed <= 1'b0;
    end else begin
      state_q <= state_d;
      armed <= (state_d == ST_ARMED);
    end
  end
endmodule

// ===== hdl/fwp_top.v
// Flash write-protect control: APB registers, unlock gating and address checking
// Summary of operation
// - Bit 31 of program protect lets the register change while one, freezes while zero.
// - Software can only clear either lock bit; only reset sets it again.
// - Program memory below 0x1D prefixed to the 24-bit boundary is protected.
// - A zero boundary disables all program flash protection.
// - Protection covers the whole page holding the boundary and all lower pages.
// - Program protect bits 30 to 24 read as zero.
// - Boot lock bit 15 lets the three boot guards change while one.
// - Boot guard bit 10 blocks writes to 0x1FC08000 through 0x1FC0BFFF.
// - Boot guard bit 9 blocks writes to 0x1FC04000 through 0x1FC07FFF.
// - Boot guard bit 8 blocks writes to 0x1FC00000 through 0x1FC03FFF.
// - Boot guards change only after unlock sequence and with boot lock set.
// - Boot register unused bits read zero; guards and lock reset to one.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/100ps
`include "fwp_map.vh"
module fwp_top (
  sys_clk,
  rst_n,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  op_req,
  op_addr,
  op_grant,
  op_reject
);
  input wire sys_clk;
  input wire rst_n;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  input wire op_req;
  input wire [31:0] op_addr;
  output reg op_grant;
  output reg op_reject;

  reg page_protect_unlock_q;
  reg [23:0] page_protect_boundary_q;
  reg boot_protect_unlock_q;
  reg boot_page2_guard_q;
  reg boot_page1_guard_q;
  reg boot_page0_guard_q;
  reg key_fail_q;
  wire armed;
  wire setup;
  wire wr_prog;
  wire wr_boot;
  wire wr_key;
  wire wr_stat;
  wire unmapped;

  // Setup cycle of APB; the slave answers in the following access cycle
  assign setup = psel && !penable;
  assign wr_prog = setup && pwrite && paddr == `FWP_ADDR_PROG;
  assign wr_boot = setup && pwrite && paddr == `FWP_ADDR_BOOT;
  assign wr_key = setup && pwrite && paddr == `FWP_ADDR_KEY;
  assign wr_stat = setup && pwrite && paddr == `FWP_ADDR_STAT;
  assign unmapped = !(paddr == `FWP_ADDR_PROG || paddr == `FWP_ADDR_BOOT ||
                      paddr == `FWP_ADDR_KEY || paddr == `FWP_ADDR_STAT);

  fwp_unlock u_unlock (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .key_wr(wr_key),
    .key_data(pwdata),
    .consume(wr_prog || wr_boot),
    .armed(armed)
  );

  function [31:0] prog_word;
    input lock;
    input [23:0] bnd;
    begin
      prog_word = `FWP_ZERO32;
      prog_word[`FWP_PROG_LOCK] = lock;
      prog_word[`FWP_PROG_BND_HI:0] = bnd;
    end
  endfunction

  function [31:0] boot_word;
    input lock;
    input g2;
    input g1;
    input g0;
    begin
      boot_word = `FWP_ZERO32;
      boot_word[`FWP_BOOT_LOCK] = lock;
      boot_word[`FWP_BOOT_G2] = g2;
      boot_word[`FWP_BOOT_G1] = g1;
      boot_word[`FWP_BOOT_G0] = g0;
    end
  endfunction

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      page_protect_unlock_q <= `FWP_LOCK_RST;
      page_protect_boundary_q <= 24'h000000;
      boot_protect_unlock_q <= `FWP_LOCK_RST;
      boot_page2_guard_q <= `FWP_LOCK_RST;
      boot_page1_guard_q <= `FWP_LOCK_RST;
      boot_page0_guard_q <= `FWP_LOCK_RST;
      key_fail_q <= 1'b0;
    end else begin
      // Writes without a fresh unlock are dropped with no slave error
      if (wr_prog && armed && page_protect_unlock_q) begin
        page_protect_boundary_q <= pwdata[`FWP_PROG_BND_HI:0];
        page_protect_unlock_q <= pwdata[`FWP_PROG_LOCK];
      end
      if (wr_boot && armed && boot_protect_unlock_q) begin
        boot_page2_guard_q <= pwdata[`FWP_BOOT_G2];
        boot_page1_guard_q <= pwdata[`FWP_BOOT_G1];
        boot_page0_guard_q <= pwdata[`FWP_BOOT_G0];
        boot_protect_unlock_q <= pwdata[`FWP_BOOT_LOCK];
      end
      // Sticky: a protect write made while not armed sets it, even if software clears in the same cycle
      if ((wr_prog || wr_boot) && !armed) begin
        key_fail_q <= 1'b1;
      end else if (wr_stat && pwdata[0]) begin
        key_fail_q <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata <= `FWP_ZERO32;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && unmapped;
      if (setup && !pwrite) begin
        if (paddr == `FWP_ADDR_PROG) begin
          prdata <= prog_word(page_protect_unlock_q, page_protect_boundary_q);
        end else if (paddr == `FWP_ADDR_BOOT) begin
          prdata <= boot_word(boot_protect_unlock_q, boot_page2_guard_q, boot_page1_guard_q, boot_page0_guard_q);
        end else if (paddr == `FWP_ADDR_STAT) begin
          prdata <= {30'h00000000, armed, key_fail_q};
        end else begin
          prdata <= `FWP_ZERO32;
        end
      end else begin
        prdata <= `FWP_ZERO32;
      end
    end
  end

  // Address checking for program and erase requests
  wire in_prog;
  wire prog_hit;
  wire in_boot;
  wire [1:0] boot_page;
  wire boot_hit;
  // Compare on page numbers so the boundary's page is covered in full
  assign in_prog = op_addr[31:24] == `FWP_PROG_HI;
  assign prog_hit = in_prog && page_protect_boundary_q != 24'h000000 &&
                    op_addr[23:`FWP_PAGE_LSB] <= page_protect_boundary_q[23:`FWP_PAGE_LSB];
  // All three boot pages share the upper half-word; page index sits just below it
  assign in_boot = op_addr[31:`FWP_BOOT_HI_LSB] == `FWP_BOOT_HI;
  assign boot_page = op_addr[`FWP_BOOT_HI_LSB-1:`FWP_BPAGE_LSB];
  assign boot_hit = in_boot && ((boot_page == 2'b10 && boot_page2_guard_q) ||
                                (boot_page == 2'b01 && boot_page1_guard_q) ||
                                (boot_page == 2'b00 && boot_page0_guard_q));

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      op_grant <= 1'b0;
      op_reject <= 1'b0;
    end else begin
      op_grant <= op_req && !(prog_hit || boot_hit);
      op_reject <= op_req && (prog_hit || boot_hit);
    end
  end
endmodule

// ===== test/fwp_chk_monitor.sv
// Port-level assertions for the flash write-protect block
`timescale 1ns/100ps
module fwp_chk_monitor (
  input wire sys_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire op_req,
  input wire [31:0] op_addr,
  input wire op_grant,
  input wire op_reject
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  a_ready_pulse: assert property (s_setup |=> s_answer) else $error("pready not one cycle after setup");
  a_unmapped_err: assert property (s_setup and (paddr > 12'h00c) |=> pready && pslverr) else $error("no slave error");
  a_prog_unused: assert property (pready && paddr == 12'h000 |-> prdata[30:24] == 7'h00)
    else $error("program protect unused bits set");
  a_boot_unused: assert property (pready && paddr == 12'h004 |-> {prdata[31:16], prdata[14:11], prdata[7:0]} == 28'h0)
    else $error("boot protect unused bits set");
  a_op_answer: assert property (op_req |=> op_grant != op_reject) else $error("op not answered once");
  a_op_quiet: assert property (!op_req |=> !op_grant && !op_reject) else $error("spurious op answer");
  a_outside_grant: assert property (op_req && op_addr[31:24] != 8'h1d && op_addr[31:16] != 16'h1fc0 |=> op_grant)
    else $error("unprotected address refused");
  a_boot_page3: assert property (op_req && op_addr[31:14] == 18'h07f03 |=> op_grant)
    else $error("beyond boot page 2 refused");
endmodule
bind fwp_top fwp_chk_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_req(op_req), .op_addr(op_addr), .op_grant(op_grant),
  .op_reject(op_reject));

// ===== test/fwp_top_tb.sv
// Self-checking bench for the flash write-protect block
`timescale 1ns/100ps
`include "fwp_map.vh"
module fwp_top_tb;
  reg sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, op_req = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, op_addr = 0, rd;
  reg er;
  wire [31:0] prdata;
  wire pready, pslverr, op_grant, op_reject;
  int failures = 0, num_checks = 0, cyc = 0;
  fwp_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_req(op_req), .op_addr(op_addr),
    .op_grant(op_grant), .op_reject(op_reject));
  initial forever #5 sys_clk = ~sys_clk;
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; leaves one idle cycle so psel is never set twice in a step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    n = 0;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20) failures++;
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge sys_clk);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task unlock;
    apb(1, `FWP_ADDR_KEY, `FWP_KEY1);
    apb(1, `FWP_ADDR_KEY, `FWP_KEY2);
  endtask
  task op(input logic [31:0] a, input logic rej);
    op_req <= 1; op_addr <= a;
    @(posedge sys_clk);
    op_req <= 0;
    @(negedge sys_clk);
    chk({op_grant, op_reject}, {~rej, rej});
    @(posedge sys_clk);
  endtask
  task t_prog;
    apb(1, 12'h000, 32'h00001234); rdc(12'h000, 32'h80000000);
    unlock(); apb(1, 12'h000, 32'hff100800); rdc(12'h000, 32'h80100800);
    op(32'h1d100fff, 1);
    op(32'h1d101000, 0);
    op(32'h1d000000, 1);
    $display("t_prog done");
  endtask
  task t_boot;
    op(32'h1fc00000, 1);
    op(32'h1fc07fff, 1);
    op(32'h1fc0bfff, 1);
    unlock(); apb(1, 12'h004, 32'h00008200); rdc(12'h004, 32'h00008200);
    op(32'h1fc00000, 0);
    op(32'h1fc04000, 1);
    op(32'h1fc08000, 0);
    $display("t_boot done");
  endtask
  task t_lock;
    unlock(); apb(1, 12'h000, 0); op(32'h1d000000, 0);
    unlock(); apb(1, 12'h000, 32'h80000800); rdc(12'h000, 0);
    unlock(); apb(1, 12'h004, 32'h00000700); rdc(12'h004, 32'h00000700);
    unlock(); apb(1, 12'h004, 32'h00008000); rdc(12'h004, 32'h00000700);
    apb(0, 12'h040, 0); chk(er, 1);
    $display("t_lock done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    rdc(12'h000, 32'h80000000);
    rdc(12'h004, 32'h00008700);
    $display("t_reset done");
    t_prog();
    t_boot();
    t_lock();
    results();
  end
endmodule
